// ==== pkg/bit_manip_regs.svh ====
// bit_manip_regs.svh: constants for the bit-manipulation execution unit.
// assumes it is included by bare name from the execution unit's design file.
`ifndef BIT_MANIP_REGS_SVH
`define BIT_MANIP_REGS_SVH

// ****************************************
// feature query leaves and bit positions
// ****************************************
`define FQ_LEAF_EXT_FEAT 32'h00000007
`define FQ_SUBLEAF_ZERO 32'h00000000
`define FQ_LEAF_EXT_CPU 32'h80000001
`define FQ_BIT_GROUP_ONE 3
`define FQ_BIT_GROUP_TWO 8
`define FQ_BIT_LEADING_ZERO 5

// ****************************************
// operand control field positions
// ****************************************
`define FX_START_LSB 0
`define FX_START_MSB 7
`define FX_LEN_LSB 8
`define FX_LEN_MSB 15
`define ZH_INDEX_LSB 0
`define ZH_INDEX_MSB 7

// ****************************************
// default widths and latency
// ****************************************
`define BMU_DEFAULT_WIDTH 64
`define BMU_RESULT_LATENCY 1

`endif

// ==== pkg/bit_manip_pkg.sv ====
// bit_manip_pkg: types shared by the bit-manipulation unit and its users.
// assumes nothing beyond a SystemVerilog compiler.
package bit_manip_pkg;

  // ****************************************
  // operation select
  // ****************************************
  typedef enum logic [3:0]
  {
    OP_AND_WITH_INVERSE,
    OP_FIELD_EXTRACT,
    OP_ISOLATE_LOWEST_ONE,
    OP_MASK_BELOW_LOWEST_ONE,
    OP_CLEAR_LOWEST_ONE,
    OP_ZERO_HIGH_FROM_INDEX,
    OP_LEADING_ZERO_COUNT,
    OP_TRAILING_ZERO_COUNT,
    OP_FLAGLESS_MULTIPLY,
    OP_MASK_DEPOSIT,
    OP_MASK_GATHER,
    OP_FLAGLESS_ROTATE_RIGHT,
    OP_ARITH_SHIFT_RIGHT,
    OP_LOGIC_SHIFT_LEFT,
    OP_LOGIC_SHIFT_RIGHT
  } op_t;

endpackage

// ==== hdl/bit_scatter_gather.sv ====
// bit_scatter_gather: combinational mask-driven deposit and gather.
// assumes source and mask are stable for the cycle in which they are sampled.
`timescale 1ns/1ps

module bit_scatter_gather #(
  parameter int WIDTH = 64
) (
  input wire logic [WIDTH-1:0] src,
  input wire logic [WIDTH-1:0] mask,
  output logic [WIDTH-1:0] deposited,
  output logic [WIDTH-1:0] gathered
);

  // ****************************************
  // scatter and gather walks
  // ****************************************
  // a ripple walk over the mask: long combinational path, traded for area
  function automatic logic [WIDTH-1:0] scatter(input logic [WIDTH-1:0] s,
                                               input logic [WIDTH-1:0] m);
    logic [WIDTH-1:0] r;
    int k;
    r = '0;
    k = 0;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (m[i])
      begin
        r[i] = s[k];
        k++;
      end
    end
    return r;
  endfunction

  function automatic logic [WIDTH-1:0] collect(input logic [WIDTH-1:0] s,
                                               input logic [WIDTH-1:0] m);
    logic [WIDTH-1:0] r;
    int k;
    r = '0;
    k = 0;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (m[i])
      begin
        r[k] = s[i];
        k++;
      end
    end
    return r;
  endfunction

  always_comb
  begin
    deposited = scatter(src, mask);
    gathered = collect(src, mask);
  end

endmodule

// ==== hdl/bit_manipulation_unit.sv ====
// bit_manipulation_unit: integer bit-manipulation execution unit.
// assumes issue logic presents operands synchronously and takes results one clock later.
`timescale 1ns/1ps
`include "bit_manip_regs.svh"

module bit_manipulation_unit #(
  parameter int WIDTH = `BMU_DEFAULT_WIDTH,
  parameter bit HAS_GROUP_ONE = 1'b1,
  parameter bit HAS_GROUP_TWO = 1'b1,
  parameter bit HAS_LEADING_ZERO = 1'b1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic opValid,
  input wire bit_manip_pkg::op_t opCode,
  input wire logic [WIDTH-1:0] srcA,
  input wire logic [WIDTH-1:0] srcB,
  input wire logic queryValid,
  input wire logic [31:0] queryLeaf,
  input wire logic [31:0] querySubleaf,
  output logic resultValid,
  output logic gprWrite,
  output logic vectorWrite,
  output logic [WIDTH-1:0] result,
  output logic [WIDTH-1:0] resultHigh,
  output logic highValid,
  output logic opRefused,
  output logic flagWrite,
  output logic carryFlag,
  output logic zeroFlag,
  output logic signFlag,
  output logic overflowFlag,
  output logic queryDone,
  output logic [31:0] secondResultWord,
  output logic [31:0] thirdResultWord
);

  localparam int SW = $clog2(WIDTH);
  localparam int CW = SW + 1;

  // ****************************************
  // width check
  // ****************************************
  if (WIDTH != 32 && WIDTH != 64)
  begin : gWidthCheck
    $error("operand width must be 32 or 64");
  end

  // ****************************************
  // shared helpers
  // ****************************************
  // ones below position n; n at or past the width gives all ones
  function automatic logic [WIDTH-1:0] lowMask(input logic [7:0] n);
    return ~({WIDTH{1'b1}} << n);
  endfunction

  function automatic logic [CW-1:0] leadZeros(input logic [WIDTH-1:0] v);
    logic [CW-1:0] c;
    logic seen;
    c = '0;
    seen = 1'b0;
    for (int i = WIDTH - 1; i >= 0; i--)
    begin
      seen = seen | v[i];
      c = c + CW'(!seen);
    end
    return c;
  endfunction

  function automatic logic [WIDTH-1:0] bitReverse(input logic [WIDTH-1:0] v);
    logic [WIDTH-1:0] r;
    for (int i = 0; i < WIDTH; i++)
    begin
      r[i] = v[WIDTH-1-i];
    end
    return r;
  endfunction

  function automatic logic groupPresent(input bit_manip_pkg::op_t op);
    logic ok;
    case (op)
      bit_manip_pkg::OP_AND_WITH_INVERSE,
      bit_manip_pkg::OP_FIELD_EXTRACT,
      bit_manip_pkg::OP_ISOLATE_LOWEST_ONE,
      bit_manip_pkg::OP_MASK_BELOW_LOWEST_ONE,
      bit_manip_pkg::OP_CLEAR_LOWEST_ONE,
      bit_manip_pkg::OP_TRAILING_ZERO_COUNT: ok = HAS_GROUP_ONE;
      bit_manip_pkg::OP_LEADING_ZERO_COUNT: ok = HAS_LEADING_ZERO;
      default: ok = HAS_GROUP_TWO;
    endcase
    return ok;
  endfunction

  // ****************************************
  // datapath
  // ****************************************
  logic [WIDTH-1:0] aMinusOne;
  logic [WIDTH-1:0] aNegated;
  logic [7:0] extStart;
  logic [7:0] extLen;
  logic [7:0] zhIndex;
  logic [SW-1:0] shiftCount;
  logic [WIDTH-1:0] extShifted;
  logic [2*WIDTH-1:0] product;
  logic [WIDTH-1:0] deposited;
  logic [WIDTH-1:0] gathered;
  logic [CW-1:0] leadCount;
  logic [CW-1:0] trailCount;
  logic srcZero;

  assign aMinusOne = srcA - WIDTH'(1);
  assign aNegated = WIDTH'(0) - srcA;
  assign extStart = srcB[`FX_START_MSB:`FX_START_LSB];
  assign extLen = srcB[`FX_LEN_MSB:`FX_LEN_LSB];
  assign zhIndex = srcB[`ZH_INDEX_MSB:`ZH_INDEX_LSB];
  // only the low count bits matter, as for the native shifts
  assign shiftCount = srcB[SW-1:0];
  assign extShifted = (int'(extStart) >= WIDTH) ? '0 : (srcA >> extStart);
  assign product = {{WIDTH{1'b0}}, srcA} * {{WIDTH{1'b0}}, srcB};
  assign leadCount = leadZeros(srcA);
  assign trailCount = leadZeros(bitReverse(srcA));
  assign srcZero = (srcA == '0);

  bit_scatter_gather #(
    .WIDTH(WIDTH)
  ) uScatterGather (
    .src(srcA),
    .mask(srcB),
    .deposited(deposited),
    .gathered(gathered)
  );

  logic [WIDTH-1:0] next_result;
  logic [WIDTH-1:0] rotated;
  logic next_carry;
  logic next_flagWrite;

  // a zero count shifts left by the full width, which gives zero as wanted
  assign rotated = (srcA >> shiftCount) | (srcA << (WIDTH'(WIDTH) - WIDTH'(shiftCount)));

  always_comb
  begin
    next_result = '0;
    case (opCode)
      bit_manip_pkg::OP_AND_WITH_INVERSE: next_result = srcA & ~srcB;
      bit_manip_pkg::OP_FIELD_EXTRACT: next_result = extShifted & lowMask(extLen);
      bit_manip_pkg::OP_ISOLATE_LOWEST_ONE: next_result = srcA & aNegated;
      bit_manip_pkg::OP_MASK_BELOW_LOWEST_ONE: next_result = srcA ^ aMinusOne;
      bit_manip_pkg::OP_CLEAR_LOWEST_ONE: next_result = srcA & aMinusOne;
      bit_manip_pkg::OP_ZERO_HIGH_FROM_INDEX: next_result = srcA & lowMask(zhIndex);
      bit_manip_pkg::OP_LEADING_ZERO_COUNT: next_result = WIDTH'(leadCount);
      bit_manip_pkg::OP_TRAILING_ZERO_COUNT: next_result = WIDTH'(trailCount);
      bit_manip_pkg::OP_FLAGLESS_MULTIPLY: next_result = product[WIDTH-1:0];
      bit_manip_pkg::OP_MASK_DEPOSIT: next_result = deposited;
      bit_manip_pkg::OP_MASK_GATHER: next_result = gathered;
      bit_manip_pkg::OP_FLAGLESS_ROTATE_RIGHT: next_result = rotated;
      bit_manip_pkg::OP_ARITH_SHIFT_RIGHT:
        next_result = WIDTH'($signed(srcA) >>> shiftCount);
      bit_manip_pkg::OP_LOGIC_SHIFT_LEFT: next_result = srcA << shiftCount;
      bit_manip_pkg::OP_LOGIC_SHIFT_RIGHT: next_result = srcA >> shiftCount;
      default: next_result = '0;
    endcase
  end

  // carry per op; the flag-free ops fall to default and leave the flags alone
  always_comb
  begin
    next_carry = 1'b0;
    next_flagWrite = 1'b1;
    case (opCode)
      bit_manip_pkg::OP_AND_WITH_INVERSE,
      bit_manip_pkg::OP_FIELD_EXTRACT: next_carry = 1'b0;
      bit_manip_pkg::OP_ISOLATE_LOWEST_ONE: next_carry = !srcZero;
      bit_manip_pkg::OP_ZERO_HIGH_FROM_INDEX: next_carry = (int'(zhIndex) > WIDTH - 1);
      bit_manip_pkg::OP_MASK_BELOW_LOWEST_ONE,
      bit_manip_pkg::OP_CLEAR_LOWEST_ONE,
      bit_manip_pkg::OP_LEADING_ZERO_COUNT,
      bit_manip_pkg::OP_TRAILING_ZERO_COUNT: next_carry = srcZero;
      default: next_flagWrite = 1'b0;
    endcase
  end

  logic accept;
  assign accept = opValid && groupPresent(opCode);

  // ****************************************
  // result registers
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      resultValid <= 1'b0;
      gprWrite <= 1'b0;
      vectorWrite <= 1'b0;
      opRefused <= 1'b0;
      highValid <= 1'b0;
    end
    else
    begin
      resultValid <= accept;
      gprWrite <= accept;
      vectorWrite <= 1'b0;
      opRefused <= opValid && !groupPresent(opCode);
      highValid <= accept && (opCode == bit_manip_pkg::OP_FLAGLESS_MULTIPLY);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      result <= '0;
      resultHigh <= '0;
    end
    else if (accept)
    begin
      result <= next_result;
      resultHigh <= product[2*WIDTH-1:WIDTH];
    end
  end

  // flags only reach the flag register for the flag-writing operations
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      flagWrite <= 1'b0;
      carryFlag <= 1'b0;
      zeroFlag <= 1'b0;
      signFlag <= 1'b0;
      overflowFlag <= 1'b0;
    end
    else
    begin
      flagWrite <= accept && next_flagWrite;
      if (accept && next_flagWrite)
      begin
        carryFlag <= next_carry;
        zeroFlag <= (next_result == '0);
        signFlag <= next_result[WIDTH-1];
        overflowFlag <= 1'b0;
      end
    end
  end

  // ****************************************
  // feature query answers
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      queryDone <= 1'b0;
      secondResultWord <= 32'h00000000;
      thirdResultWord <= 32'h00000000;
    end
    else
    begin
      queryDone <= queryValid;
      if (queryValid)
      begin
        secondResultWord <= 32'h00000000;
        thirdResultWord <= 32'h00000000;
        if (queryLeaf == `FQ_LEAF_EXT_FEAT && querySubleaf == `FQ_SUBLEAF_ZERO)
        begin
          secondResultWord[`FQ_BIT_GROUP_ONE] <= HAS_GROUP_ONE;
          secondResultWord[`FQ_BIT_GROUP_TWO] <= HAS_GROUP_TWO;
        end
        else if (queryLeaf == `FQ_LEAF_EXT_CPU)
        begin
          thirdResultWord[`FQ_BIT_LEADING_ZERO] <= HAS_LEADING_ZERO;
        end
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cbAst @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence seqIssue(bit_manip_pkg::op_t op);
    opValid && opCode == op && groupPresent(op);
  endsequence
  sequence seqRetire;
    resultValid && gprWrite;
  endsequence

  AST_AND_NOT: assert property (seqIssue(bit_manip_pkg::OP_AND_WITH_INVERSE) |=>
    seqRetire ##0 (result == ($past(srcA) & ~$past(srcB))))
    else $error("and-not result wrong");
  AST_EXTRACT: assert property (seqIssue(bit_manip_pkg::OP_FIELD_EXTRACT)
    ##0 (extStart == 8'h00 && int'(extLen) >= WIDTH) |=> result == $past(srcA))
    else $error("full-width extract did not return source");
  AST_ISOLATE: assert property (seqIssue(bit_manip_pkg::OP_ISOLATE_LOWEST_ONE)
    |=> $onehot0(result) && (result & $past(aMinusOne)) == '0)
    else $error("isolate left more than the lowest one");
  AST_MASK: assert property (seqIssue(bit_manip_pkg::OP_MASK_BELOW_LOWEST_ONE)
    |=> result == (($past(srcA) & $past(aNegated)) - WIDTH'(1) | ($past(srcA) & $past(aNegated))))
    else $error("mask below lowest one wrong");
  AST_CLEAR: assert property (seqIssue(bit_manip_pkg::OP_CLEAR_LOWEST_ONE)
    |=> result == ($past(srcA) & ~($past(srcA) & $past(aNegated))))
    else $error("clear-lowest changed wrong bits");
  AST_ZERO_HIGH: assert property (seqIssue(bit_manip_pkg::OP_ZERO_HIGH_FROM_INDEX)
    ##0 (int'(zhIndex) < WIDTH) |=> (result >> $past(zhIndex)) == '0 && carryFlag == 1'b0)
    else $error("zero-high kept high bits");
  AST_LEAD: assert property (seqIssue(bit_manip_pkg::OP_LEADING_ZERO_COUNT)
    ##0 srcZero |=> result == WIDTH'(WIDTH) && carryFlag)
    else $error("leading count of zero source wrong");
  AST_TRAIL: assert property (seqIssue(bit_manip_pkg::OP_TRAILING_ZERO_COUNT)
    ##0 srcA[0] |=> result == '0 && !carryFlag && zeroFlag)
    else $error("trailing count of odd source wrong");
  AST_MULTIPLY: assert property (seqIssue(bit_manip_pkg::OP_FLAGLESS_MULTIPLY)
    |=> !flagWrite && highValid && {resultHigh, result} == $past(srcA) * $past(srcB))
    else $error("flagless multiply wrong or wrote flags");
  AST_GATHER_ALL: assert property (seqIssue(bit_manip_pkg::OP_MASK_GATHER)
    ##0 (&srcB) |=> result == $past(srcA) && !flagWrite)
    else $error("gather with full mask changed source");
  AST_DEPOSIT_ALL: assert property (seqIssue(bit_manip_pkg::OP_MASK_DEPOSIT)
    ##0 (&srcB) |=> result == $past(srcA))
    else $error("deposit with full mask changed source");
  AST_ROTATE: assert property (seqIssue(bit_manip_pkg::OP_FLAGLESS_ROTATE_RIGHT)
    |=> !flagWrite && $countones(result) == $countones($past(srcA)) && $stable(carryFlag))
    else $error("rotate lost bits or touched flags");
  AST_SAR_SIGN: assert property (seqIssue(bit_manip_pkg::OP_ARITH_SHIFT_RIGHT)
    |=> result[WIDTH-1] == $past(srcA[WIDTH-1]))
    else $error("arithmetic shift lost sign");
  AST_NO_VECTOR: assert property (opValid |-> ##1 !vectorWrite [*3])
    else $error("vector register written");
  AST_QUERY: assert property (queryValid && queryLeaf == `FQ_LEAF_EXT_FEAT
    && querySubleaf == `FQ_SUBLEAF_ZERO |=> queryDone
    && secondResultWord[`FQ_BIT_GROUP_ONE] == HAS_GROUP_ONE
    && secondResultWord[`FQ_BIT_GROUP_TWO] == HAS_GROUP_TWO)
    else $error("group flags misreported");
  AST_QUERY_EXT: assert property (queryValid && queryLeaf == `FQ_LEAF_EXT_CPU
    |=> thirdResultWord[`FQ_BIT_LEADING_ZERO] == HAS_LEADING_ZERO && secondResultWord == '0)
    else $error("leading count flag misreported");

endmodule

// ==== testbench/bmu_partner.sv ====
// bmu_partner: issue-side model that holds the general registers the unit writes back.
// assumes results arrive as one-cycle write pulses on the rising edge of mclk.
`timescale 1ns/1ps

module bmu_partner #(
  parameter int WIDTH = 64
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic gprWrite,
  input wire logic vectorWrite,
  input wire logic highValid,
  input wire logic [WIDTH-1:0] result,
  input wire logic [WIDTH-1:0] resultHigh,
  output logic [WIDTH-1:0] gprLow,
  output logic [WIDTH-1:0] gprHigh,
  output logic [7:0] vecWriteCount
);
  // ****************************************
  // general register write-back
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (rst)
      gprLow <= '0;
    else if (gprWrite)
      gprLow <= result;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      gprHigh <= '0;
    else if (highValid)
      gprHigh <= resultHigh;
  end

  // ****************************************
  // vector side: nothing may ever land here
  // ****************************************
  // counted rather than flagged so a single stray pulse still shows at the end
  always_ff @(posedge mclk)
  begin
    if (rst)
      vecWriteCount <= 8'h00;
    else if (vectorWrite)
      vecWriteCount <= vecWriteCount + 8'h01;
  end
endmodule

// ==== testbench/testbench.sv ====
// testbench: directed scenarios for the bit-manipulation unit at 64-bit width.
// assumes the unit answers one clock after each accepted operation or query.
`timescale 1ns/1ps

module testbench;
  localparam int W = 64;
  logic mclk, rst, opValid, queryValid;
  bit_manip_pkg::op_t opCode;
  logic [W-1:0] srcA, srcB, result, resultHigh, gprLow, gprHigh;
  logic [31:0] queryLeaf, querySubleaf, secondResultWord, thirdResultWord, noTwoSecond;
  logic resultValid, gprWrite, vectorWrite, highValid, opRefused, flagWrite;
  logic carryFlag, zeroFlag, signFlag, overflowFlag, queryDone, noTwoRefused;
  logic [7:0] vecWriteCount;
  int badCount = 0;
  int nCompared = 0;

  // ****************************************
  // units under test and register-file model
  // ****************************************
  bit_manipulation_unit #(.WIDTH(W)) dut_u (.mclk(mclk), .rst(rst), .opValid(opValid),
    .opCode(opCode), .srcA(srcA), .srcB(srcB), .queryValid(queryValid),
    .queryLeaf(queryLeaf), .querySubleaf(querySubleaf), .resultValid(resultValid),
    .gprWrite(gprWrite), .vectorWrite(vectorWrite), .result(result),
    .resultHigh(resultHigh), .highValid(highValid), .opRefused(opRefused),
    .flagWrite(flagWrite), .carryFlag(carryFlag), .zeroFlag(zeroFlag),
    .signFlag(signFlag), .overflowFlag(overflowFlag), .queryDone(queryDone),
    .secondResultWord(secondResultWord), .thirdResultWord(thirdResultWord));

  // same stimulus, second group absent: must refuse and must not advertise it
  bit_manipulation_unit #(.WIDTH(W), .HAS_GROUP_TWO(1'b0)) dut_no_two_u (.mclk(mclk),
    .rst(rst), .opValid(opValid), .opCode(opCode), .srcA(srcA), .srcB(srcB),
    .queryValid(queryValid), .queryLeaf(queryLeaf), .querySubleaf(querySubleaf),
    .resultValid(), .gprWrite(), .vectorWrite(), .result(), .resultHigh(),
    .highValid(), .opRefused(noTwoRefused), .flagWrite(), .carryFlag(), .zeroFlag(),
    .signFlag(), .overflowFlag(), .queryDone(), .secondResultWord(noTwoSecond),
    .thirdResultWord());

  bmu_partner #(.WIDTH(W)) partner_u (.mclk(mclk), .rst(rst), .gprWrite(gprWrite),
    .vectorWrite(vectorWrite), .highValid(highValid), .result(result),
    .resultHigh(resultHigh), .gprLow(gprLow), .gprHigh(gprHigh),
    .vecWriteCount(vecWriteCount));

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // ****************************************
  // comparison, verdict and reference model
  // ****************************************
  task automatic check(input logic [W-1:0] seen, input logic [W-1:0] expv);
    nCompared++;
    if (seen !== expv)
    begin
      badCount++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask

  task automatic tally_and_finish();
    if (badCount == 0 && nCompared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  function automatic logic [W-1:0] expect_op(input bit_manip_pkg::op_t op,
                                             input logic [W-1:0] a, input logic [W-1:0] b);
    logic [W-1:0] r;
    int k;
    int n;
    r = '0;
    n = 0;
    case (op)
      bit_manip_pkg::OP_AND_WITH_INVERSE: r = a & ~b;
      bit_manip_pkg::OP_FIELD_EXTRACT:
      begin
        r = (b[7:0] >= W) ? '0 : a >> b[7:0];
        if (b[15:8] < W)
          r = r & ((64'h1 << b[15:8]) - 64'h1);
      end
      bit_manip_pkg::OP_ISOLATE_LOWEST_ONE: r = a & (~a + 64'h1);
      bit_manip_pkg::OP_MASK_BELOW_LOWEST_ONE: r = a ^ (a - 64'h1);
      bit_manip_pkg::OP_CLEAR_LOWEST_ONE: r = a & (a - 64'h1);
      bit_manip_pkg::OP_ZERO_HIGH_FROM_INDEX:
        r = (b[7:0] > W - 1) ? a : a & ((64'h1 << b[7:0]) - 64'h1);
      bit_manip_pkg::OP_LEADING_ZERO_COUNT:
        for (k = W - 1; k >= 0 && a[k] == 1'b0; k--) r++;
      bit_manip_pkg::OP_TRAILING_ZERO_COUNT:
        for (k = 0; k < W && a[k] == 1'b0; k++) r++;
      bit_manip_pkg::OP_FLAGLESS_MULTIPLY: r = a * b;
      bit_manip_pkg::OP_MASK_DEPOSIT:
        for (k = 0; k < W; k++)
          if (b[k])
          begin
            r[k] = a[n];
            n++;
          end
      bit_manip_pkg::OP_MASK_GATHER:
        for (k = 0; k < W; k++)
          if (b[k])
          begin
            r[n] = a[k];
            n++;
          end
      bit_manip_pkg::OP_FLAGLESS_ROTATE_RIGHT: r = (a >> b[5:0]) | (a << (W - b[5:0]));
      bit_manip_pkg::OP_ARITH_SHIFT_RIGHT: r = $signed(a) >>> b[5:0];
      bit_manip_pkg::OP_LOGIC_SHIFT_LEFT: r = a << b[5:0];
      default: r = a >> b[5:0];
    endcase
    return r;
  endfunction

  // ****************************************
  // drivers: entered and left at a falling edge
  // ****************************************
  task automatic op_check(input bit_manip_pkg::op_t op, input logic [W-1:0] a,
                          input logic [W-1:0] b);
    logic [W-1:0] expv;
    logic [2*W-1:0] full;
    logic isTwo;
    logic noFlags;
    int k;
    expv = expect_op(op, a, b);
    full = {{W{1'b0}}, a} * {{W{1'b0}}, b};
    isTwo = op inside {bit_manip_pkg::OP_ZERO_HIGH_FROM_INDEX,
      bit_manip_pkg::OP_FLAGLESS_MULTIPLY, bit_manip_pkg::OP_MASK_DEPOSIT,
      bit_manip_pkg::OP_MASK_GATHER, bit_manip_pkg::OP_FLAGLESS_ROTATE_RIGHT,
      bit_manip_pkg::OP_ARITH_SHIFT_RIGHT, bit_manip_pkg::OP_LOGIC_SHIFT_LEFT,
      bit_manip_pkg::OP_LOGIC_SHIFT_RIGHT};
    noFlags = isTwo && op != bit_manip_pkg::OP_ZERO_HIGH_FROM_INDEX;
    opCode = op;
    srcA = a;
    srcB = b;
    opValid = 1'b1;
    @(negedge mclk);
    opValid = 1'b0;
    k = 0;
    while (resultValid !== 1'b1 && k < 4)
    begin
      @(negedge mclk);
      k++;
    end
    if (k == 4)
    begin
      badCount++;
      tally_and_finish();
    end
    check(result, expv);
    check(gprWrite, 1'b1);
    check(opRefused, 1'b0);
    check(vectorWrite, 1'b0);
    check(noTwoRefused, isTwo);
    check(highValid, op == bit_manip_pkg::OP_FLAGLESS_MULTIPLY);
    if (op == bit_manip_pkg::OP_FLAGLESS_MULTIPLY)
      check(resultHigh, full[2*W-1:W]);
    check(flagWrite, !noFlags);
    @(negedge mclk);
    check(gprLow, expv);
    check(resultValid, 1'b0);
  endtask

  task automatic query(input logic [31:0] leaf, input logic [31:0] sub);
    int k;
    queryLeaf = leaf;
    querySubleaf = sub;
    queryValid = 1'b1;
    @(negedge mclk);
    queryValid = 1'b0;
    k = 0;
    while (queryDone !== 1'b1 && k < 4)
    begin
      @(negedge mclk);
      k++;
    end
    if (k == 4)
    begin
      badCount++;
      tally_and_finish();
    end
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic group_one_ops();
    op_check(bit_manip_pkg::OP_AND_WITH_INVERSE, 64'hf0f0_1234_ffff_0000, 64'h0ff0_0204_00ff_ff00);
    op_check(bit_manip_pkg::OP_FIELD_EXTRACT, 64'h8765_4321_abcd_ef12, 64'h0000_0000_0000_0c24);
    op_check(bit_manip_pkg::OP_FIELD_EXTRACT, 64'h8765_4321_abcd_ef12, 64'h0000_0000_0000_4004);
    op_check(bit_manip_pkg::OP_FIELD_EXTRACT, 64'hffff_ffff_ffff_ffff, 64'h0000_0000_0000_0840);
    op_check(bit_manip_pkg::OP_ISOLATE_LOWEST_ONE, 64'h8000_0000_0003_5800, 64'h0);
    op_check(bit_manip_pkg::OP_MASK_BELOW_LOWEST_ONE, 64'h0000_0100_0000_0000, 64'h0);
    op_check(bit_manip_pkg::OP_CLEAR_LOWEST_ONE, 64'h8000_0000_0000_0000, 64'h0);
    op_check(bit_manip_pkg::OP_CLEAR_LOWEST_ONE, 64'h0000_00f0_0000_0c00, 64'h0);
    op_check(bit_manip_pkg::OP_TRAILING_ZERO_COUNT, 64'h0000_0000_0004_0000, 64'h0);
    op_check(bit_manip_pkg::OP_TRAILING_ZERO_COUNT, 64'h8000_0000_0000_0000, 64'h0);
  endtask

  task automatic group_two_ops();
    op_check(bit_manip_pkg::OP_ZERO_HIGH_FROM_INDEX, 64'hffff_ffff_ffff_ffff, 64'h3f);
    op_check(bit_manip_pkg::OP_ZERO_HIGH_FROM_INDEX, 64'h1234_5678_9abc_def0, 64'h40);
    op_check(bit_manip_pkg::OP_LEADING_ZERO_COUNT, 64'h0000_0000_0010_0000, 64'h0);
    op_check(bit_manip_pkg::OP_LEADING_ZERO_COUNT, 64'h0, 64'h0);
    op_check(bit_manip_pkg::OP_FLAGLESS_MULTIPLY, 64'hffff_ffff_ffff_ffff, 64'hffff_ffff_ffff_fffe);
    op_check(bit_manip_pkg::OP_MASK_DEPOSIT, 64'h0000_0000_0000_00b5, 64'h8001_0f00_0000_f00a);
    op_check(bit_manip_pkg::OP_MASK_GATHER, 64'h8421_5a5a_0ff0_c3c3, 64'hf000_00ff_8001_0306);
    op_check(bit_manip_pkg::OP_FLAGLESS_ROTATE_RIGHT, 64'h0123_4567_89ab_cdef, 64'h44);
    op_check(bit_manip_pkg::OP_ARITH_SHIFT_RIGHT, 64'h8000_0000_0000_1230, 64'h3f);
    op_check(bit_manip_pkg::OP_LOGIC_SHIFT_LEFT, 64'h8000_0000_0000_1231, 64'h41);
    op_check(bit_manip_pkg::OP_LOGIC_SHIFT_RIGHT, 64'h8000_0000_0000_1230, 64'h3f);
  endtask

  // flags raised by a count must survive the flag-free operations that follow
  task automatic flags_kept();
    op_check(bit_manip_pkg::OP_TRAILING_ZERO_COUNT, 64'h0, 64'h0);
    check(carryFlag, 1'b1);
    op_check(bit_manip_pkg::OP_FLAGLESS_MULTIPLY, 64'h3, 64'h5);
    check(carryFlag, 1'b1);
    op_check(bit_manip_pkg::OP_CLEAR_LOWEST_ONE, 64'h1, 64'h0);
    check(carryFlag, 1'b0);
    check(zeroFlag, 1'b1);
    op_check(bit_manip_pkg::OP_FLAGLESS_ROTATE_RIGHT, 64'h0, 64'h1);
    check(carryFlag, 1'b0);
    op_check(bit_manip_pkg::OP_ISOLATE_LOWEST_ONE, 64'h8000_0000_0000_0000, 64'h0);
    check({signFlag, zeroFlag, carryFlag}, 3'h5);
  endtask

  task automatic back_to_back();
    opCode = bit_manip_pkg::OP_MASK_GATHER;
    srcA = 64'hffff_0000_ffff_0000;
    srcB = 64'h0f0f_0f0f_0f0f_0f0f;
    opValid = 1'b1;
    @(negedge mclk);
    opCode = bit_manip_pkg::OP_AND_WITH_INVERSE;
    check(result, 64'h0000_0000_ff00_ff00);
    @(negedge mclk);
    opValid = 1'b0;
    check(result, 64'hf0f0_0000_f0f0_0000);
    check(resultValid, 1'b1);
    @(negedge mclk);
  endtask

  task automatic feature_queries();
    query(32'h0000_0007, 32'h0000_0000);
    check(secondResultWord[3], 1'b1);
    check(secondResultWord[8], 1'b1);
    check(noTwoSecond[8], 1'b0);
    check(noTwoSecond[3], 1'b1);
    @(negedge mclk);
    query(32'h8000_0001, 32'h0000_0005);
    check(thirdResultWord[5], 1'b1);
    @(negedge mclk);
    query(32'h0000_0003, 32'h0000_0000);
    check({secondResultWord, thirdResultWord}, 64'h0);
    @(negedge mclk);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    rst = 1'b1;
    opValid = 1'b0;
    opCode = bit_manip_pkg::OP_AND_WITH_INVERSE;
    srcA = '0;
    srcB = '0;
    queryValid = 1'b0;
    queryLeaf = 32'h0;
    querySubleaf = 32'h0;
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    check({resultValid, queryDone, carryFlag, overflowFlag}, 4'h0);
    check(result, 64'h0);
    group_one_ops();
    group_two_ops();
    flags_kept();
    back_to_back();
    feature_queries();
    check(vecWriteCount, 8'h00);
    check(overflowFlag, 1'b0);
    tally_and_finish();
  end
endmodule
